// *** common/stm_pkg.sv ***
// Constants and types for the standard timer block
`default_nettype none
package stm_pkg;
    localparam int          CNT_W       = 10;
    localparam int          TICK_DIV    = 4;
    localparam logic [7:0]  OFS_CTRL0   = 8'h00;
    localparam logic [7:0]  OFS_CTRL1   = 8'h04;
    localparam logic [7:0]  OFS_COUNT   = 8'h08;
    localparam logic [7:0]  OFS_CMPA    = 8'h0C;
    localparam logic [7:0]  OFS_FLAGS   = 8'h10;
    localparam int          ON_BIT      = 3;
    localparam int          FLAG_A_BIT  = 0;
    localparam int          FLAG_P_BIT  = 1;
    localparam logic [3:0]  CTRL0_RST   = 4'h0;
    localparam logic [7:0]  CTRL1_RST   = 8'h00;
    localparam logic [9:0]  CMPA_RST    = 10'h000;
    localparam logic [9:0]  CNT_MAX     = 10'h3FF;
    localparam logic [10:0] FULL_SPAN   = 11'h400;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} stm_mode_t;

    typedef struct packed {
        stm_mode_t  mode;
        logic [1:0] pin_function;
        logic       output_level_control;
        logic       output_invert;
        logic       period_duty_swap;
        logic       clear_source_select;
    } stm_ctrl1_t;
endpackage
`default_nettype wire

// *** rtl/stm_timer.sv ***
// Standard 10-bit timer with compare, capture and PWM modes behind AXI4-Lite
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module stm_timer
    import stm_pkg::*;
#(
    parameter int TICK_DIVIDE = TICK_DIV
) (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        TIMER_PIN_IN,
    output logic             TIMER_PIN_OUT,
    output logic             TIMER_PIN_OE,
    output logic             MATCH_A_FLAG,
    output logic             MATCH_P_FLAG
);
    // Bus state
    logic [7:0]  aw_addr,  next_aw_addr;
    logic        aw_full,  next_aw_full;
    logic [31:0] w_data,   next_w_data;
    logic [3:0]  w_strb,   next_w_strb;
    logic        w_full,   next_w_full;
    logic        bvalid,   next_bvalid;
    logic [1:0]  bresp,    next_bresp;
    logic        rvalid,   next_rvalid;
    logic [31:0] rdata,    next_rdata;
    logic [1:0]  rresp,    next_rresp;
    // Timer state
    logic [3:0]  ctrl0,    next_ctrl0;
    stm_ctrl1_t  ctrl1,    next_ctrl1;
    logic [9:0]  cmpa,     next_cmpa;
    logic [9:0]  cnt,      next_cnt;
    logic        on_q,     next_on_q;
    logic        pin_lvl,  next_pin_lvl;
    logic        flag_a,   next_flag_a;
    logic        flag_p,   next_flag_p;
    logic        pin_out,  next_pin_out;
    logic        pin_oe,   next_pin_oe;
    logic [7:0]  div,      next_div;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    // Combinational helpers
    logic        wr_fire;
    logic        tick;
    logic        on;
    logic        on_rise;
    logic        run;
    logic [9:0]  cnt_inc;
    logic [2:0]  period;
    logic        match_a;
    logic        match_p;
    logic        clr;
    logic        single;
    logic        cap_evt;
    logic        pwm_act;
    logic [10:0] duty;
    logic        lvl;
    logic        a_hit;
    logic        set_a;
    logic        set_p;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        case (a)
            OFS_CTRL0: read_mux = {28'h000_0000, ctrl0};
            OFS_CTRL1: read_mux = {24'h00_0000, ctrl1};
            OFS_COUNT: read_mux = {22'h00_0000, cnt};
            OFS_CMPA:  read_mux = {22'h00_0000, cmpa};
            OFS_FLAGS: read_mux = {30'h0000_0000, flag_p, flag_a};
            default:   read_mux = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_COUNT) || (a == OFS_CMPA) || (a == OFS_FLAGS);
    endfunction

    assign S_AXI_AWREADY = !aw_full && !bvalid;
    assign S_AXI_WREADY  = !w_full && !bvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;
    assign TIMER_PIN_OUT = pin_out;
    assign TIMER_PIN_OE  = pin_oe;
    assign MATCH_A_FLAG  = flag_a;
    assign MATCH_P_FLAG  = flag_p;

    // Tick, match and capture decode
    always_comb begin
        wr_fire = aw_full && w_full && !bvalid;
        tick    = (div == 8'(TICK_DIVIDE - 1));
        on      = ctrl0[ON_BIT];
        on_rise = on && !on_q;
        run     = on && tick && !on_rise;
        cnt_inc = cnt + 10'h001;
        period  = ctrl0[2:0];
        single  = (ctrl1.mode == MODE_PWM) && (ctrl1.pin_function == 2'b11);
        match_a = (cnt_inc == cmpa);
        match_p = (period != 3'h0) ? ((cnt_inc[9:7] == period) && (cnt_inc[6:0] == 7'h00)) : (cnt == CNT_MAX);
        unique case (ctrl1.mode)
            MODE_CMP, MODE_TMR: clr = ctrl1.clear_source_select ? match_a : match_p;
            MODE_PWM:           clr = single ? 1'b0 : (ctrl1.period_duty_swap ? match_a : match_p);
            MODE_CAP:           clr = match_p;
        endcase
        unique case (ctrl1.pin_function)
            2'b00: cap_evt = pin_s2 && !pin_s3;
            2'b01: cap_evt = !pin_s2 && pin_s3;
            2'b10: cap_evt = pin_s2 != pin_s3;
            2'b11: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && on && (ctrl1.mode == MODE_CAP);
        if (ctrl1.period_duty_swap) begin
            duty = (period == 3'h0) ? FULL_SPAN : {1'b0, period, 7'h00};
        end else begin
            duty = {1'b0, cmpa};
        end
        pwm_act = ({1'b0, cnt} < duty);
        a_hit   = run && match_a && (ctrl1.mode != MODE_CAP);
        set_a   = a_hit || cap_evt;
        set_p   = run && match_p && !single
                  && !(((ctrl1.mode == MODE_CMP) || (ctrl1.mode == MODE_TMR)) && ctrl1.clear_source_select);
        unique case (ctrl1.pin_function)
            2'b00: lvl = !ctrl1.output_level_control;
            2'b01: lvl = ctrl1.output_level_control;
            2'b10: lvl = pwm_act ? ctrl1.output_level_control : !ctrl1.output_level_control;
            2'b11: lvl = on ? ctrl1.output_level_control : !ctrl1.output_level_control;
        endcase
        if (ctrl1.mode == MODE_CMP) begin
            lvl = pin_lvl;
        end
    end

    // Next state of bus and timer
    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_full = aw_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_w_full  = w_full;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_ctrl0   = ctrl0;
        next_ctrl1   = ctrl1;
        next_cmpa    = cmpa;
        next_cnt     = cnt;
        next_on_q    = on;
        next_pin_lvl = pin_lvl;
        next_flag_a  = flag_a;
        next_flag_p  = flag_p;
        next_div     = tick ? 8'h00 : div + 8'h01;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_addr = S_AXI_AWADDR;
            next_aw_full = 1'b1;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
            next_w_full = 1'b1;
        end
        if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rdata  = read_mux(S_AXI_ARADDR);
            next_rresp  = known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        if (on_rise) begin
            next_cnt = 10'h000;
        end else if (run) begin
            next_cnt = clr ? 10'h000 : cnt_inc;
        end
        if (single && a_hit) begin
            next_ctrl0[ON_BIT] = 1'b0;
        end
        if (on_rise) begin
            next_pin_lvl = ctrl1.output_level_control;
        end else if ((ctrl1.mode == MODE_CMP) && a_hit) begin
            unique case (ctrl1.pin_function)
                2'b00: next_pin_lvl = pin_lvl;
                2'b01: next_pin_lvl = 1'b0;
                2'b10: next_pin_lvl = 1'b1;
                2'b11: next_pin_lvl = !pin_lvl;
            endcase
        end
        if (cap_evt) begin
            next_cmpa = cnt;
        end
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (w_strb[0]) begin
                unique case (aw_addr)
                    OFS_CTRL0: next_ctrl0 = w_data[3:0];
                    OFS_CTRL1: next_ctrl1 = stm_ctrl1_t'(w_data[7:0]);
                    OFS_CMPA:  next_cmpa[7:0] = w_data[7:0];
                    OFS_FLAGS: begin
                        next_flag_a = flag_a && !w_data[FLAG_A_BIT];
                        next_flag_p = flag_p && !w_data[FLAG_P_BIT];
                    end
                    default: ;
                endcase
            end
            if (w_strb[1] && (aw_addr == OFS_CMPA)) begin
                next_cmpa[9:8] = w_data[9:8];
            end
        end
        next_flag_a = next_flag_a || set_a;
        next_flag_p = next_flag_p || set_p;
        next_pin_out = ((ctrl1.mode == MODE_CMP) || (ctrl1.mode == MODE_PWM)) && (lvl ^ ctrl1.output_invert);
        next_pin_oe  = (ctrl1.mode == MODE_CMP) || (ctrl1.mode == MODE_PWM);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            aw_addr <= 8'h00;
            aw_full <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            w_full  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
            ctrl0   <= CTRL0_RST;
            ctrl1   <= stm_ctrl1_t'(CTRL1_RST);
            cmpa    <= CMPA_RST;
            cnt     <= 10'h000;
            on_q    <= 1'b0;
            pin_lvl <= 1'b0;
            flag_a  <= 1'b0;
            flag_p  <= 1'b0;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
            div     <= 8'h00;
            pin_s1  <= 1'b0;
            pin_s2  <= 1'b0;
            pin_s3  <= 1'b0;
        end else begin
            aw_addr <= next_aw_addr;
            aw_full <= next_aw_full;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            w_full  <= next_w_full;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
            ctrl0   <= next_ctrl0;
            ctrl1   <= next_ctrl1;
            cmpa    <= next_cmpa;
            cnt     <= next_cnt;
            on_q    <= next_on_q;
            pin_lvl <= next_pin_lvl;
            flag_a  <= next_flag_a;
            flag_p  <= next_flag_p;
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
            div     <= next_div;
            pin_s1  <= TIMER_PIN_IN;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_on_rise;
        !on ##1 on;
    endsequence

    chk_cnt_restart: assert property (s_on_rise |=> cnt == 10'h000)
        else $error("counter not cleared on start");
    chk_pin_initial: assert property (s_on_rise ##0 ctrl1.mode == MODE_CMP |=> pin_lvl == $past(ctrl1.output_level_control))
        else $error("pin not at initial level after start");
    chk_p_blocked: assert property (ctrl1.mode == MODE_CMP && ctrl1.clear_source_select && !flag_p |=> !flag_p)
        else $error("P flag raised with clear source A");
    chk_p_on_boundary: assert property (!flag_p ##1 flag_p |-> $past(cnt[6:0]) == 7'h7F)
        else $error("P match off a 128 boundary");
    chk_overflow_wrap: assert property (run && period == 3'h0 && cnt == CNT_MAX |=> cnt == 10'h000)
        else $error("counter did not wrap at maximum");
    chk_toggle_pin: assert property (ctrl1.mode == MODE_CMP && ctrl1.pin_function == 2'b11 && a_hit && !on_rise
                                     |=> pin_lvl != $past(pin_lvl))
        else $error("toggle did not move the pin");
    chk_capture_load: assert property (cap_evt && !wr_fire |=> cmpa == $past(cnt) && flag_a)
        else $error("capture did not load compare A");
    chk_timer_pin_free: assert property (ctrl1.mode == MODE_TMR |=> !TIMER_PIN_OE && !TIMER_PIN_OUT)
        else $error("pin driven in timer mode");
    chk_flag_sticky: assert property (flag_a && !(wr_fire && aw_addr == OFS_FLAGS) |=> flag_a)
        else $error("A flag dropped without clear");
endmodule
`default_nettype wire

// *** tb/stm_pin_model.sv ***
// Far-side pin model sharing the timer pin
`default_nettype none
module stm_pin_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic ext_lvl,
    output logic      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_in = pin_oe ? pin_out : ext_lvl;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the standard timer
`default_nettype none
module tb_top
    import stm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TD = 2;
    logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic        arready, rvalid, rready, pin_in, pin_out, pin_oe, fa, fp, ext, e;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    int          n_errors, checks_done, cyc, t0, t1, hi, oc, iv, pt, dt, f;
    stm_timer #(.TICK_DIVIDE(TD)) stm_timer_i (
        .CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIMER_PIN_IN(pin_in), .TIMER_PIN_OUT(pin_out),
        .TIMER_PIN_OE(pin_oe), .MATCH_A_FLAG(fa), .MATCH_P_FLAG(fp)
    );
    stm_pin_model stm_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] s);
        checks_done++;
        if (s !== ex) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, ex, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tmo();
        n_errors++;
        $display("ERROR wait expected done seen timeout");
        final_report();
    endtask
    // One write or read, held until its response is taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tr, tv;
        int n;
        @(posedge clk);
        awaddr  <= a;
        araddr  <= a;
        wdata   <= v;
        awvalid <= w;
        wvalid  <= w;
        arvalid <= !w;
        bready  <= w;
        rready  <= !w;
        for (n = 0; n < 99; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            tv = w ? bvalid : rvalid;
            r  = w ? bresp : rresp;
            d  = rdata;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (tv) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (n == 99) tmo();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
        cmp("bresp", 32'(RESP_OKAY), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0000_0000);
        cmp("rresp", 32'(RESP_OKAY), 32'(r));
        cmp("rdata", ex, d);
    endtask
    task automatic wt(input logic p, output int t);
        int n;
        for (n = 0; n < 5000; n++) begin
            @(negedge clk);
            if ((p ? fp : fa) === 1'b1) break;
        end
        if (n == 5000) tmo();
        t = cyc;
    endtask
    task automatic cfg(input logic [7:0] c1, input logic [9:0] ca, input logic [2:0] per);
        wr(OFS_CTRL0, 32'h0000_0000);
        wr(OFS_CMPA, {22'h0, ca});
        wr(OFS_CTRL1, {24'h0, c1});
        wr(OFS_FLAGS, 32'h0000_0003);
        wr(OFS_CTRL0, {28'h0, 1'b1, per});
    endtask
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, ext} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        void'($urandom(79691));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        // Reset values and unmapped places
        for (int a = 0; a <= 20; a += 4) begin
            bus(1'b0, a[7:0], 32'h0000_0000);
            cmp("reset_val", 32'h0000_0000, d);
            cmp("rresp", 32'((a == 20) ? RESP_SLVERR : RESP_OKAY), 32'(r));
        end
        bus(1'b1, 8'h14, 32'h0000_0001);
        cmp("bresp", 32'(RESP_SLVERR), 32'(r));
        hi = $urandom % 256;
        wr(OFS_CTRL1, 32'(hi));
        rd(OFS_CTRL1, 32'(hi));
        // Period spacing of P matches
        for (int p = 0; p < 3; p++) begin
            cfg({MODE_CMP, 6'h00}, 10'h005, p[2:0]);
            wt(1'b1, t0);
            wr(OFS_FLAGS, 32'h0000_0002);
            wt(1'b1, t1);
            cmp("p_period", 32'((p == 0 ? 1024 : 128 * p) * TD), 32'(t1 - t0));
            cmp("a_flag", 32'h0000_0001, 32'(fa));
        end
        // Clear on A match, P flag silent
        cfg({MODE_CMP, 6'h01}, 10'h12C, 3'h1);
        wt(1'b0, t0);
        wr(OFS_FLAGS, 32'h0000_0001);
        wt(1'b0, t1);
        cmp("a_period", 32'(300 * TD), 32'(t1 - t0));
        cmp("p_flag", 32'h0000_0000, 32'(fp));
        // Compare pin actions for every code and level
        for (f = 0; f < 4; f++) begin
            for (oc = 0; oc < 2; oc++) begin
                iv = $urandom % 2;
                e = (f == 0) ? oc[0] : (f == 3) ? !oc[0] : f[1];
                cfg({MODE_CMP, f[1:0], oc[0], iv[0], 2'b00}, 10'h028, 3'h1);
                repeat (3) @(negedge clk);
                cmp("pin_init", 32'(oc[0] ^ iv[0]), 32'(pin_out));
                cmp("pin_oe", 32'h0000_0001, 32'(pin_oe));
                wt(1'b0, t0);
                repeat (3) @(negedge clk);
                cmp("pin_match", 32'(e ^ iv[0]), 32'(pin_out));
                wt(1'b1, t0);
                repeat (3) @(negedge clk);
                cmp("pin_at_p", 32'(e ^ iv[0]), 32'(pin_out));
            end
        end
        cfg({MODE_TMR, 6'h3F}, 10'h028, 3'h1);
        wt(1'b0, t0);
        cmp("oe_timer", 32'h0000_0000, 32'(pin_oe));
        // PWM forced levels, waveform, swapped roles
        oc = $urandom % 2;
        iv = $urandom % 2;
        for (int k = 0; k < 4; k++) begin
            f  = (k < 2) ? k : 2;
            pt = (k == 3) ? 512 : 128;
            dt = (k == 0) ? 0 : (k == 1) ? pt : (k == 3) ? 128 : 32;
            cfg({MODE_PWM, f[1:0], oc[0], iv[0], k == 3, 1'b1}, (k == 3) ? 10'h200 : 10'h020, 3'h1);
            repeat (pt * TD) @(negedge clk);
            hi = 0;
            repeat (2 * pt * TD) begin
                @(negedge clk);
                hi += int'(pin_out === (oc[0] ^ iv[0]));
            end
            cmp("pwm_active", 32'(2 * dt * TD), 32'(hi));
        end
        // Single pulse: active from start, ends on match A
        cfg({MODE_PWM, 2'b11, oc[0], iv[0], 2'b00}, 10'h010, 3'h1);
        @(negedge clk);
        cmp("pulse_lead", 32'(oc[0] ^ iv[0]), 32'(pin_out));
        wt(1'b0, t0);
        repeat (3) @(negedge clk);
        cmp("pulse_trail", 32'(!(oc[0] ^ iv[0])), 32'(pin_out));
        rd(OFS_CTRL0, 32'h0000_0001);
        // Capture edges for every code
        for (f = 0; f < 4; f++) begin
            cfg({MODE_CAP, f[1:0], 4'h0}, 10'h3FF, 3'h0);
            for (int l = 1; l >= 0; l--) begin
                @(posedge clk);
                ext <= l[0];
                repeat (10) @(negedge clk);
                cmp("cap_flag", 32'(f == 2 || f == 1 - l), 32'(fa));
                wr(OFS_FLAGS, 32'h0000_0001);
                @(negedge clk);
                cmp("flag_clear", 32'h0000_0000, 32'(fa));
            end
        end
        // Byte strobes steer the compare A bytes
        wr(OFS_CMPA, 32'h0000_0155);
        @(posedge clk);
        wstrb <= 4'h1;
        wr(OFS_CMPA, 32'h0000_02AA);
        rd(OFS_CMPA, 32'h0000_01AA);
        @(posedge clk);
        wstrb <= 4'h2;
        wr(OFS_CMPA, 32'h0000_0055);
        rd(OFS_CMPA, 32'h0000_00AA);
        @(posedge clk);
        wstrb <= 4'hF;
        // Counter holds when stopped, clears on restart
        wr(OFS_CTRL0, 32'h0000_0000);
        bus(1'b0, OFS_COUNT, 32'h0000_0000);
        t0 = int'(d);
        cmp("count_run", 32'h0000_0001, 32'(t0 > 8));
        repeat (20) @(negedge clk);
        rd(OFS_COUNT, 32'(t0));
        wr(OFS_CTRL0, 32'h0000_0008);
        bus(1'b0, OFS_COUNT, 32'h0000_0000);
        cmp("count_clear", 32'h0000_0001, 32'(d < 32'h0000_0002));
        final_report();
    end
endmodule
`default_nettype wire
